/* File: hdl/supply_ctrl_map.vh */
// register map, field positions, reset values and counts of the supply controller
`ifndef SUPPLY_CTRL_MAP_VH
`define SUPPLY_CTRL_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SUPPLY_COMMAND_OFS 8'h00
`define MONITOR_MODE_OFS 8'h04
`define SUPPLY_MODE_OFS 8'h08
`define WAKE_MODE_OFS 8'h0C
`define WAKE_INPUTS_OFS 8'h10
`define SUPPLY_STATUS_OFS 8'h14

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MONITOR_MODE_RST 32'h0000_0000
`define SUPPLY_MODE_RST 32'h0000_0A00
`define WAKE_MODE_RST 32'h0000_0000
`define WAKE_INPUTS_RST 32'h0000_0000

// ----------------------------------------------------------------------
// key field, command and mode fields
// ----------------------------------------------------------------------
`define PASSWORD_MSB 31
`define PASSWORD_LSB 24
`define PASSWORD_KEY 8'hA5
`define CMD_REG_STOP_BIT 2
`define CMD_XTAL_SEL_BIT 3
`define MR_BROWNOUT_RST_BIT 12
`define MR_BROWNOUT_DIS_BIT 13
`define MR_REG_USE_BIT 14
`define MR_OSC_BYPASS_BIT 20

// ----------------------------------------------------------------------
// monitor mode fields
// ----------------------------------------------------------------------
`define SM_THRESHOLD_MSB 3
`define SM_THRESHOLD_LSB 0
`define SM_SAMPLING_MSB 10
`define SM_SAMPLING_LSB 8
`define SM_RESET_EN_BIT 12
`define SM_IRQ_EN_BIT 13
`define SM_OFF 3'h0
`define SM_CONTINUOUS 3'h1
`define SM_EVERY_32 3'h2
`define SM_EVERY_256 3'h3
`define SM_EVERY_2048 3'h4

// ----------------------------------------------------------------------
// wake mode fields
// ----------------------------------------------------------------------
`define WM_MONITOR_EN_BIT 1
`define WM_TIMER_EN_BIT 2
`define WM_CALENDAR_EN_BIT 3
`define WM_TAMPER_EN0_BIT 5
`define WM_TAMPER_CLR_BIT 7
`define WM_WAKE_DBC_MSB 14
`define WM_WAKE_DBC_LSB 12
`define WM_TAMPER_DBC_MSB 18
`define WM_TAMPER_DBC_LSB 16

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define SR_WAKE_PIN_BIT 1
`define SR_MON_WAKE_BIT 2
`define SR_BROWNOUT_RST_BIT 3
`define SR_MON_RST_BIT 4
`define SR_MON_EVENT_BIT 5
`define SR_MON_OUT_BIT 6
`define SR_OSC_SEL_BIT 7
`define SR_TAMPER0_BIT 13
`define SR_WAKE_INPUT_LSB 16

// ----------------------------------------------------------------------
// debounce and sampling counts, in slow clock periods
// ----------------------------------------------------------------------
`define WAKE_DBC_CNT_1 16'd3
`define WAKE_DBC_CNT_2 16'd32
`define WAKE_DBC_CNT_3 16'd512
`define WAKE_DBC_CNT_4 16'd4096
`define WAKE_DBC_CNT_5 16'd32768
`define SM_PERIOD_MASK_32 11'h01F
`define SM_PERIOD_MASK_256 11'h0FF
`define SM_PERIOD_MASK_2048 11'h7FF
`define STATUS_CLR_DELAY 2

`endif

/* File: hdl/supply_ctrl.v */
// supply controller register block with wake-up, tamper and core reset logic
`timescale 1ns/1ps
`include "supply_ctrl_map.vh"

// What this block does
// - command and supply mode writes need key 0xA5
// - regulator stop asserts core reset, then stops
// - crystal select switches slow clock; zero ignored
// - write protect blocks all configuration writes
// - sampling field sets monitor duty: off/on/32/256/2048
// - monitor reset enable routes detection to reset
// - monitor irq enable routes detection to irq
// - brownout reset enable routes brownout to reset while the regulator use bit is set
// - brownout disable turns detector off
// - regulator use bit selects core supply source
// - bypass forces crystal in bypass mode
// - monitor wake enable lets detection wake core
// - timer alarm wake enable lets alarm wake
// - calendar alarm wake enable lets alarm wake
// - tamper debouncer enables connect pins zero, one
// - tamper clear wipes lower backup registers
// - registers live in backup domain, retained
// - reset values zero, mode register 0xA00
// - wake debounce 0..5: 1,3,32,512,4096,32768 periods
// - tamper period 0 off, 1..7 needs 2..8
// - wake inputs have enable and polarity
// - status read clears flags two cycles later

module supply_ctrl #(
	parameter ADDR_W = 8,
	parameter WAKE_PINS = 16,
	parameter [15:0] WAKE_DBC_CNT_5 = `WAKE_DBC_CNT_5
) (
	input wire clk,
	input wire nrst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire write_protect_enable,
	input wire [WAKE_PINS-1:0] wake_pin,
	input wire sampling_waveform_out,
	input wire monitor_low,
	input wire brownout_ok,
	input wire timer_alarm,
	input wire calendar_alarm,
	output wire core_nrst,
	output wire regulator_off,
	output wire regulator_use,
	output wire brownout_disable,
	output wire crystal_select,
	output wire oscillator_bypass,
	output wire monitor_on,
	output wire [3:0] monitor_threshold,
	output wire supply_irq,
	output wire wake_core,
	output wire backup_scratch_regs_clear
);

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	localparam SYNC_W = WAKE_PINS + 5;
	wire [SYNC_W-1:0] raw_in;
	wire [SYNC_W-1:0] clean_in;
	assign raw_in = {wake_pin, sampling_waveform_out, monitor_low, brownout_ok,
		timer_alarm, calendar_alarm};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			reg clean_ff;
			// a change counts only once stages two and three agree
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					// brownout_ok idles high: its chain starts high so no false loss follows reset
					s1_ff <= (gi == 2);
					s2_ff <= (gi == 2);
					s3_ff <= (gi == 2);
					clean_ff <= (gi == 2);
				end else begin
					s1_ff <= raw_in[gi];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff) begin
						clean_ff <= s3_ff;
					end
				end
			end
			assign clean_in[gi] = clean_ff;
		end
	endgenerate

	wire [WAKE_PINS-1:0] pin_s;
	wire wave_s;
	wire mon_low_s;
	wire bod_ok_s;
	wire rtt_s;
	wire rtc_s;
	assign {pin_s, wave_s, mon_low_s, bod_ok_s, rtt_s, rtc_s} = clean_in;

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	// all state below sits in the always-powered domain: only the backup
	// power-on reset (nrst) clears it, core power loss does not
	reg [31:0] mon_mode_ff;
	reg [23:0] sup_mode_ff;
	reg [31:0] wake_mode_ff;
	reg [31:0] wake_in_ff;
	reg xtal_sel_ff;
	reg reg_stop_ff;
	reg vreg_off_ff;
	localparam [31:0] SUP_MODE_RST = `SUPPLY_MODE_RST;

	// ------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------
	reg aw_hold_ff;
	reg w_hold_ff;
	reg [ADDR_W-1:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg rvalid_ff;
	reg [1:0] rresp_ff;
	reg [31:0] rdata_ff;

	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready = !w_hold_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// true for the six word offsets the block decodes
	function mapped;
		input [ADDR_W-1:0] a;
		begin
			mapped = (a[1:0] == 2'b00) && (a <= `SUPPLY_STATUS_OFS);
		end
	endfunction

	wire wr_go;
	wire rd_go;
	wire key_ok;
	wire wr_open;
	assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign rd_go = s_axi_arvalid && !rvalid_ff;
	assign key_ok = (wdata_ff[`PASSWORD_MSB:`PASSWORD_LSB] == `PASSWORD_KEY);
	assign wr_open = wr_go && !write_protect_enable;

	// address and data are captured independently, the write fires once both are held
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= {ADDR_W{1'b0}};
			wdata_ff <= 32'h0000_0000;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'b00;
		end else begin
			if (s_axi_awvalid && !aw_hold_ff) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_ff) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= mapped(awaddr_ff) ? 2'b00 : 2'b10;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// register writes; protected or badly keyed writes are dropped whole
	// and still answered okay, so software sees no bus error
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mon_mode_ff <= `MONITOR_MODE_RST;
			sup_mode_ff <= SUP_MODE_RST[23:0];
			wake_mode_ff <= `WAKE_MODE_RST;
			wake_in_ff <= `WAKE_INPUTS_RST;
		end else if (wr_open) begin
			case (awaddr_ff)
				`MONITOR_MODE_OFS: begin
					mon_mode_ff <= wdata_ff & 32'h0000_370F;
				end
				`SUPPLY_MODE_OFS: begin
					if (key_ok) begin
						sup_mode_ff <= wdata_ff[23:0];
					end
				end
				`WAKE_MODE_OFS: begin
					wake_mode_ff <= wdata_ff & 32'h0007_70EE;
				end
				`WAKE_INPUTS_OFS: begin
					wake_in_ff <= wdata_ff;
				end
				default: begin
					mon_mode_ff <= mon_mode_ff;
				end
			endcase
		end
	end

	wire cmd_wr;
	assign cmd_wr = wr_open && key_ok && (awaddr_ff == `SUPPLY_COMMAND_OFS);

	// ------------------------------------------------------------------
	// supply monitor sampling
	// ------------------------------------------------------------------
	reg [10:0] sm_cnt_ff;
	reg sm_out_ff;
	reg sm_det;
	wire [2:0] sm_mode;
	reg sm_active;
	assign sm_mode = mon_mode_ff[`SM_SAMPLING_MSB:`SM_SAMPLING_LSB];

	// monitor powered one slow period per window, or always, or never
	always @* begin
		case (sm_mode)
			`SM_CONTINUOUS: sm_active = 1'b1;
			`SM_EVERY_32: sm_active = ((sm_cnt_ff & `SM_PERIOD_MASK_32) == 11'h000);
			`SM_EVERY_256: sm_active = ((sm_cnt_ff & `SM_PERIOD_MASK_256) == 11'h000);
			`SM_EVERY_2048: sm_active = ((sm_cnt_ff & `SM_PERIOD_MASK_2048) == 11'h000);
			default: sm_active = 1'b0;
		endcase
		sm_det = sm_active && mon_low_s;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sm_cnt_ff <= 11'h000;
			sm_out_ff <= 1'b0;
		end else begin
			sm_cnt_ff <= sm_cnt_ff + 11'h001;
			if (sm_active) begin
				sm_out_ff <= mon_low_s;
			end
		end
	end

	assign monitor_on = sm_active;
	assign monitor_threshold = mon_mode_ff[`SM_THRESHOLD_MSB:`SM_THRESHOLD_LSB];

	// ------------------------------------------------------------------
	// wake-up inputs and their shared debounce counter
	// ------------------------------------------------------------------
	wire [WAKE_PINS-1:0] pin_hit;
	wire pin_any;
	reg [15:0] wk_cnt_ff;
	reg wk_done_ff;
	wire [15:0] wk_need;
	wire wk_fire;
	assign pin_hit = wake_in_ff[WAKE_PINS-1:0] & ~(pin_s ^ wake_in_ff[16 +: WAKE_PINS]);
	assign pin_any = |pin_hit;

	// active periods required by the debounce field
	function [15:0] wake_need;
		input [2:0] code;
		begin
			case (code)
				3'h1: wake_need = `WAKE_DBC_CNT_1;
				3'h2: wake_need = `WAKE_DBC_CNT_2;
				3'h3: wake_need = `WAKE_DBC_CNT_3;
				3'h4: wake_need = `WAKE_DBC_CNT_4;
				3'h5: wake_need = WAKE_DBC_CNT_5;
				default: wake_need = 16'd1;
			endcase
		end
	endfunction

	assign wk_need = wake_need(wake_mode_ff[`WM_WAKE_DBC_MSB:`WM_WAKE_DBC_LSB]);
	assign wk_fire = pin_any && !wk_done_ff && ((wk_cnt_ff + 16'd1) >= wk_need);

	// one wake per assertion: a new one needs the inputs to go idle first
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wk_cnt_ff <= 16'd0;
			wk_done_ff <= 1'b0;
		end else if (!pin_any) begin
			wk_cnt_ff <= 16'd0;
			wk_done_ff <= 1'b0;
		end else begin
			if (wk_cnt_ff != 16'hFFFF) begin
				wk_cnt_ff <= wk_cnt_ff + 16'd1;
			end
			if (wk_fire) begin
				wk_done_ff <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// low-power tamper debouncers on wake pins zero and one
	// ------------------------------------------------------------------
	reg wave_d_ff;
	wire sample_pt;
	wire [2:0] lp_code;
	wire [1:0] lp_fire;
	assign sample_pt = wave_d_ff && !wave_s; // falling edge of the sampling waveform
	assign lp_code = wake_mode_ff[`WM_TAMPER_DBC_MSB:`WM_TAMPER_DBC_LSB];

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wave_d_ff <= 1'b0;
		end else begin
			wave_d_ff <= wave_s;
		end
	end

	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_tamper
			reg [3:0] lp_cnt_ff;
			reg lp_done_ff;
			wire lp_en;
			wire lp_act;
			assign lp_en = wake_mode_ff[`WM_TAMPER_EN0_BIT + gi] && (lp_code != 3'h0);
			assign lp_act = (pin_s[gi] == wake_in_ff[16 + gi]);
			assign lp_fire[gi] = lp_en && sample_pt && lp_act && !lp_done_ff &&
				((lp_cnt_ff + 4'h1) >= ({1'b0, lp_code} + 4'h1));
			// successive identical samples are counted at each sampling point
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					lp_cnt_ff <= 4'h0;
					lp_done_ff <= 1'b0;
				end else if (!lp_en) begin
					lp_cnt_ff <= 4'h0;
					lp_done_ff <= 1'b0;
				end else if (sample_pt) begin
					if (!lp_act) begin
						lp_cnt_ff <= 4'h0;
						lp_done_ff <= 1'b0;
					end else begin
						if (lp_cnt_ff != 4'hF) begin
							lp_cnt_ff <= lp_cnt_ff + 4'h1;
						end
						if (lp_fire[gi]) begin
							lp_done_ff <= 1'b1;
						end
					end
				end
			end
		end
	endgenerate

	// the clear leaves combinationally so the wipe carries no delay
	assign backup_scratch_regs_clear = wake_mode_ff[`WM_TAMPER_CLR_BIT] && (|lp_fire);

	// ------------------------------------------------------------------
	// wake request to the core power sequence
	// ------------------------------------------------------------------
	wire mon_wake;
	wire wake_now;
	assign mon_wake = wake_mode_ff[`WM_MONITOR_EN_BIT] && sm_det;
	assign wake_now = wk_fire || (|lp_fire) || mon_wake ||
		(wake_mode_ff[`WM_TIMER_EN_BIT] && rtt_s) ||
		(wake_mode_ff[`WM_CALENDAR_EN_BIT] && rtc_s);
	reg wake_ff;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= wake_now;
		end
	end
	assign wake_core = wake_ff;

	// ------------------------------------------------------------------
	// core reset, regulator stop and slow clock selection
	// ------------------------------------------------------------------
	reg bod_low_d_ff;
	reg nrst_core_ff;
	wire bod_armed;
	wire bod_lost;
	wire sm_rst;
	assign bod_armed = sup_mode_ff[`MR_BROWNOUT_RST_BIT] && !sup_mode_ff[`MR_BROWNOUT_DIS_BIT] &&
		sup_mode_ff[`MR_REG_USE_BIT] && !vreg_off_ff;
	// brownout must be missing more than one slow period before it resets
	assign bod_lost = bod_armed && !bod_ok_s && bod_low_d_ff;
	assign sm_rst = mon_mode_ff[`SM_RESET_EN_BIT] && sm_det;

	// regulator stop holds reset low first; the regulator stops one period
	// later so the core is never running while its supply collapses
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xtal_sel_ff <= 1'b0;
			reg_stop_ff <= 1'b0;
			vreg_off_ff <= 1'b0;
			bod_low_d_ff <= 1'b0;
			nrst_core_ff <= 1'b1;
		end else begin
			bod_low_d_ff <= !bod_ok_s;
			if (cmd_wr && wdata_ff[`CMD_XTAL_SEL_BIT]) begin
				xtal_sel_ff <= 1'b1;
			end
			if (cmd_wr && wdata_ff[`CMD_REG_STOP_BIT]) begin
				reg_stop_ff <= 1'b1;
			end else if (wake_ff) begin
				reg_stop_ff <= 1'b0;
			end
			if (wake_ff) begin
				vreg_off_ff <= 1'b0;
			end else if (reg_stop_ff && !nrst_core_ff) begin
				vreg_off_ff <= 1'b1;
			end
			nrst_core_ff <= !(reg_stop_ff || vreg_off_ff || sm_rst || bod_lost);
		end
	end

	assign core_nrst = nrst_core_ff;
	assign regulator_off = vreg_off_ff;
	assign regulator_use = sup_mode_ff[`MR_REG_USE_BIT];
	assign brownout_disable = sup_mode_ff[`MR_BROWNOUT_DIS_BIT];
	assign oscillator_bypass = sup_mode_ff[`MR_OSC_BYPASS_BIT];
	assign crystal_select = xtal_sel_ff || sup_mode_ff[`MR_OSC_BYPASS_BIT];

	// ------------------------------------------------------------------
	// status flags and read path
	// ------------------------------------------------------------------
	reg [31:0] flags_ff;
	reg [`STATUS_CLR_DELAY-1:0] clr_pipe_ff;
	reg [31:0] flag_set;
	wire [31:0] status_word;

	// event bits that hardware raises; a raise beats a pending clear
	always @* begin
		flag_set = 32'h0000_0000;
		flag_set[`SR_WAKE_PIN_BIT] = wk_fire;
		flag_set[`SR_MON_WAKE_BIT] = mon_wake;
		flag_set[`SR_BROWNOUT_RST_BIT] = bod_armed && !bod_ok_s && !bod_low_d_ff;
		flag_set[`SR_MON_RST_BIT] = sm_rst;
		flag_set[`SR_MON_EVENT_BIT] = sm_det;
		flag_set[`SR_TAMPER0_BIT] = lp_fire[0];
		flag_set[`SR_TAMPER0_BIT + 1] = lp_fire[1];
		flag_set[31:16] = wk_fire ? pin_hit : 16'h0000;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags_ff <= 32'h0000_0000;
			clr_pipe_ff <= {`STATUS_CLR_DELAY{1'b0}};
		end else begin
			clr_pipe_ff <= {clr_pipe_ff[`STATUS_CLR_DELAY-2:0],
				rd_go && (s_axi_araddr == `SUPPLY_STATUS_OFS)};
			if (clr_pipe_ff[`STATUS_CLR_DELAY-1]) begin
				flags_ff <= flag_set;
			end else begin
				flags_ff <= flags_ff | flag_set;
			end
		end
	end

	assign status_word = flags_ff | {24'h000000, crystal_select, sm_out_ff, 6'h00};
	assign supply_irq = mon_mode_ff[`SM_IRQ_EN_BIT] && flags_ff[`SR_MON_EVENT_BIT];

	// read data is registered; the command register reads as zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= 2'b00;
			rdata_ff <= 32'h0000_0000;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
			case (s_axi_araddr)
				`MONITOR_MODE_OFS: rdata_ff <= mon_mode_ff;
				`SUPPLY_MODE_OFS: rdata_ff <= {8'h00, sup_mode_ff};
				`WAKE_MODE_OFS: rdata_ff <= wake_mode_ff;
				`WAKE_INPUTS_OFS: rdata_ff <= wake_in_ff;
				`SUPPLY_STATUS_OFS: rdata_ff <= status_word;
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

endmodule // supply_ctrl

/* File: verif/supply_ctrl_assertions.sv */
// assertion checker bound to the supply controller top
`timescale 1ns/1ps
module supply_ctrl_checker #(
	parameter ADDR_W = 8
) (
	input wire clk,
	input wire nrst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire core_nrst,
	input wire regulator_off,
	input wire crystal_select,
	input wire oscillator_bypass,
	input wire backup_scratch_regs_clear
);
// ----------------
// bus answers and control outputs
// ----------------
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
	s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
	s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
	$stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
	|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
a_bypass_xtal: assert property (oscillator_bypass |-> crystal_select)
	else $error("bypass without crystal");
a_xtal_sticky: assert property (crystal_select && !oscillator_bypass |=> crystal_select)
	else $error("crystal choice lost");
a_stop_order: assert property ($rose(regulator_off) |-> !core_nrst &&
	$past(core_nrst) == 1'b0) else $error("regulator stopped before reset");
a_clear_pulse: assert property (backup_scratch_regs_clear |=> !backup_scratch_regs_clear)
	else $error("clear pulse too long");
// main scenarios reached
c_write: cover property (s_axi_bvalid && s_axi_bready);
c_stop: cover property ($rose(regulator_off));
c_clear: cover property (backup_scratch_regs_clear);
endmodule // supply_ctrl_checker

bind supply_ctrl supply_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: verif/supply_ctrl_tb.sv */
// self-checking bench for the supply controller
`timescale 1ns/1ps
module supply_ctrl_tb;
// ----------------
// signals and design
// ----------------
logic clk = 1'b0, nrst = 1'b0;
logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0;
logic [3:0] s_axi_wstrb = 4'hF;
// answer readies stay high, so every answer is taken at the edge it is first seen
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
logic write_protect_enable = 1'b0, sampling_waveform_out = 1'b0, monitor_low = 1'b0;
logic brownout_ok = 1'b1, timer_alarm = 1'b0, calendar_alarm = 1'b0;
logic [15:0] wake_pin = '0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire core_nrst, regulator_off, regulator_use, brownout_disable, crystal_select;
wire oscillator_bypass, monitor_on, supply_irq, wake_core, backup_scratch_regs_clear;
wire [3:0] monitor_threshold;
int errors = 0, total_checks = 0, wakes = 0, clrs = 0, lows = 0, cycles = 0, n, k;
logic [31:0] rv;
logic [1:0] resp;

// long top debounce count shortened to keep the run brief
supply_ctrl #(.WAKE_DBC_CNT_5(16'h0010)) dut (.*);

// 4 ns clock
always #2 clk = ~clk;

// event counters on the falling edge so tests read them race-free
always @(negedge clk) begin
	cycles++;
	if (wake_core) wakes++;
	if (backup_scratch_regs_clear) clrs++;
	if (!core_nrst) lows++;
	if (cycles == 60000) begin
		errors++;
		finish_test();
	end
end

task finish_test;
	$display("checks %0d mismatches %0d", total_checks, errors);
	if (errors == 0 && total_checks > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask

task chk(input logic [31:0] s, input logic [31:0] e);
	total_checks++;
	if (s !== e) begin
		errors++;
		$display("unexpected at %0t: seen %h expected %h", $time, s, e);
	end
endtask

task cyc(input int c);
	repeat (c) @(posedge clk);
endtask

task rst;
	nrst <= 1'b0;
	cyc(2);
	nrst <= 1'b1;
	cyc(1);
endtask

// ----------------
// bus tasks: sample at the falling edge, drive after the rising edge
// ----------------
task wr(input logic [7:0] a, input logic [31:0] d);
	logic aw, w, b;
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	b = 1'b0;
	while (!b) begin
		@(negedge clk);
		aw = s_axi_awvalid & s_axi_awready;
		w = s_axi_wvalid & s_axi_wready;
		b = s_axi_bvalid & s_axi_bready;
		resp = s_axi_bresp;
		@(posedge clk);
		if (aw) s_axi_awvalid <= 1'b0;
		if (w) s_axi_wvalid <= 1'b0;
	end
endtask

task rd(input logic [7:0] a, output logic [31:0] d);
	logic ar, r;
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	r = 1'b0;
	while (!r) begin
		@(negedge clk);
		ar = s_axi_arvalid & s_axi_arready;
		r = s_axi_rvalid & s_axi_rready;
		d = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge clk);
		if (ar) s_axi_arvalid <= 1'b0;
	end
endtask

// ----------------
// scenarios
// ----------------
task t_reset;
	logic [31:0] ev [5] = '{32'h0, 32'h0A00, 32'h0, 32'h0, 32'h0};
	rst();
	for (int i = 0; i < 5; i++) begin
		rd(8'(i * 4 + 4), rv);
		chk(rv, ev[i]);
	end
	rd(8'h18, rv);
	chk(32'(resp), 32'h2);
	wr(8'h18, 32'h0);
	chk(32'(resp), 32'h2);
	$display("reset values done");
endtask

// bad key, good key, then a protected write that must not land
task t_mode;
	logic [31:0] wv [4] = '{32'h5A105000, 32'hA5105000, 32'hA5002000, 32'hA5105000};
	logic [31:0] ev [4] = '{32'h0A00, 32'h105000, 32'h2000, 32'h2000};
	rst();
	for (int i = 0; i < 4; i++) begin
		write_protect_enable <= (i == 3);
		wr(8'h08, wv[i]);
		rd(8'h08, rv);
		chk(rv, ev[i]);
		chk(32'({oscillator_bypass, crystal_select, regulator_use, brownout_disable}),
			32'({ev[i][20], ev[i][20], ev[i][14], ev[i][13]}));
	end
	write_protect_enable <= 1'b0;
	$display("mode register done");
endtask

task t_cmd;
	rst();
	wr(8'h00, 32'h5A00000C);
	cyc(8);
	chk(32'({core_nrst, crystal_select}), 32'h2);
	wr(8'h00, 32'hA5000008);
	wr(8'h00, 32'hA5000000);
	chk(32'(crystal_select), 32'h1);
	wr(8'h00, 32'hA5000004);
	cyc(4);
	chk(32'({core_nrst, regulator_off}), 32'h1);
	rd(8'h14, rv);
	chk(32'(rv[7]), 32'h1);
	$display("command register done");
endtask

// powered cycles counted over one full 2048-cycle span per code
task t_sample;
	int ex [5] = '{0, 2048, 64, 8, 1};
	rst();
	for (int s = 0; s < 5; s++) begin
		wr(8'h04, 32'(s) << 8 | 32'h5);
		chk(32'(monitor_threshold), 32'h5);
		n = 0;
		repeat (2048) begin
			@(negedge clk);
			n += monitor_on;
		end
		@(posedge clk);
		chk(32'(n), 32'(ex[s]));
	end
	$display("monitor sampling done");
endtask

task t_monitor;
	for (int en = 0; en < 2; en++) begin
		rst();
		wr(8'h0C, 32'(en) << 1);
		wr(8'h04, 32'(en) * 32'h3000 | 32'h0100);
		n = wakes;
		k = lows;
		monitor_low <= 1'b1;
		cyc(12);
		chk(32'(supply_irq), 32'(en));
		chk(32'(lows > k), 32'(en));
		chk(32'(wakes > n), 32'(en));
		monitor_low <= 1'b0;
		cyc(6);
		rd(8'h14, rv);
		chk(32'(rv[5]), 32'h1);
		cyc(4);
		rd(8'h14, rv);
		cyc(2);
		chk(32'({rv[5], supply_irq}), 32'h0);
		// brownout with the regulator in use, reset routing on or off
		wr(8'h08, 32'hA5004000 | 32'(en) << 12);
		k = lows;
		brownout_ok <= 1'b0;
		cyc(10);
		chk(32'(lows > k), 32'(en));
		brownout_ok <= 1'b1;
		cyc(8);
		rd(8'h14, rv);
		chk(32'(rv[3]), 32'(en));
	end
	$display("monitor and brownout events done");
endtask

task t_alarm;
	for (int i = 0; i < 4; i++) begin
		rst();
		wr(8'h0C, 32'(i[0]) << (2 + i[1]));
		n = wakes;
		{calendar_alarm, timer_alarm} <= 2'h1 << i[1];
		cyc(10);
		chk(32'(wakes > n), 32'(i[0]));
		{calendar_alarm, timer_alarm} <= 2'h0;
	end
	$display("alarm wake done");
endtask

// every debounce code; no wake before the count, wake soon after
task t_wake_pin;
	int need [6] = '{1, 3, 32, 512, 4096, 16};
	for (int c = 0; c < 6; c++) begin
		rst();
		wr(8'h10, 32'h00010001);
		wr(8'h0C, 32'(c) << 12);
		n = wakes;
		wake_pin[0] <= 1'b1;
		cyc(need[c] + 1);
		chk(32'(wakes), 32'(n));
		cyc(10);
		chk(32'(wakes > n), 32'h1);
		wake_pin[0] <= 1'b0;
		rd(8'h14, rv);
		chk(rv & 32'h00010002, 32'h00010002);
	end
	$display("wake pins done");
endtask

task t_tamper;
	logic [31:0] m [3] = '{32'h000100A0, 32'h00010020, 32'h000000A0};
	for (int i = 0; i < 3; i++) begin
		rst();
		wr(8'h10, 32'h00010000);
		wr(8'h0C, m[i]);
		n = wakes;
		k = clrs;
		wake_pin[0] <= 1'b1;
		repeat (4) begin
			sampling_waveform_out <= 1'b1;
			cyc(8);
			sampling_waveform_out <= 1'b0;
			cyc(8);
		end
		chk(32'(clrs > k), 32'(m[i][7] & m[i][16]));
		chk(32'(wakes > n), 32'(m[i][16]));
		wake_pin[0] <= 1'b0;
	end
	$display("tamper done");
endtask

// main sequence
initial begin
	t_reset();
	t_mode();
	t_cmd();
	t_sample();
	t_monitor();
	t_alarm();
	t_wake_pin();
	t_tamper();
	finish_test();
end
endmodule // supply_ctrl_tb
